// >>> fsrb_pkg.sv
// constants and types of the fault state report bank
package fsrb_pkg;

	// =========================================================
	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int IDX_W = 10;

	// =========================================================
	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CH34_STATE = 10'h00e;
	localparam logic [IDX_W-1:0] IDX_OCDC_MEM = 10'h00f;
	localparam logic [IDX_W-1:0] IDX_SUPPLY_MEM = 10'h010;
	localparam logic [IDX_W-1:0] IDX_SUPPLY_LIVE = 10'h011;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h020;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h021;

	// =========================================================
	// values after reset
	localparam logic [REG_W-1:0] RST_CH34_STATE = 8'h24;
	localparam logic [REG_W-1:0] RST_MEM = 8'h00;
	localparam logic [REG_W-1:0] RST_LIVE = 8'h00;
	localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

	// =========================================================
	// field positions
	localparam int CH3_STATE_LSB = 5;
	localparam int CH4_STATE_LSB = 2;
	localparam int CH3_LOAD_OK_BIT = 1;
	localparam int CH4_LOAD_OK_BIT = 0;
	localparam int OC_LSB = 4;
	localparam int DC_LSB = 0;
	localparam int GATE_FAULT_BIT = 5;
	localparam int DIG_POR_BIT = 4;
	localparam int WARN_BIT = 7;
	localparam int FAULT_BIT = 6;
	localparam logic [REG_W-1:0] SUPPLY_MEM_MASK = 8'h3f;
	localparam logic [REG_W-1:0] SUPPLY_LIVE_MASK = 8'hef;

	// =========================================================
	// interrupt status bits
	localparam int IRQ_W = 5;
	localparam int IRQ_OC = 0;
	localparam int IRQ_DC = 1;
	localparam int IRQ_SUPPLY = 2;
	localparam int IRQ_SHUTDOWN = 3;
	localparam int IRQ_LOAD_OK = 4;
	localparam logic [IRQ_W-1:0] RST_IRQ = 5'h00;

	typedef enum logic [2:0] {
		fsrb_playing = 3'h0,
		fsrb_high_impedance_state = 3'h1,
		fsrb_muted = 3'h2,
		fsrb_diagnostic_state = 3'h3,
		fsrb_shutdown_auto_recover = 3'h4,
		fsrb_protective_shutdown = 3'h5
	} fsrb_chan_state_t;

endpackage

// >>> fsrb_acc_if.sv
// access strobes passed from the bus port to the register core
`timescale 1ns/1ps
interface fsrb_acc_if;
	import fsrb_pkg::*;
	logic setup;
	logic take;
	logic wr;
	logic mapped_ok;
	logic [IDX_W-1:0] idx;
	modport port (output setup, output take, output wr,
		output mapped_ok, output idx);
	modport core (input setup, input take, input wr,
		input mapped_ok, input idx);
endinterface

// >>> fsrb_apb_port.sv
// apb handshake front end of the fault state report bank
`timescale 1ns/1ps
module fsrb_apb_port import fsrb_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	output logic pready,
	fsrb_acc_if.port acc
);

	wire logic setup_w;

	assign setup_w = psel & ~penable;

	// fixed one-cycle access phase: ready follows every setup cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_w;
		end
	end

	assign acc.setup = setup_w;
	assign acc.take = psel & penable & pready;
	assign acc.wr = pwrite;
	assign acc.idx = paddr[ADDR_W-1:2];
	assign acc.mapped_ok = (paddr[1:0] == 2'h0);

endmodule

// >>> fsrb_event_latch.sv
// sticky event bits with per-bit clear, a set beats a clear
`timescale 1ns/1ps
module fsrb_event_latch import fsrb_pkg::*; #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			wire logic next_q;
			assign next_q = set[i] | (q[i] & ~clr[i]);
			always_ff @(posedge clk) begin
				if (rst) begin
					q[i] <= 1'b0;
				end else begin
					q[i] <= next_q;
				end
			end
		end
	endgenerate

endmodule

// >>> fsrb_top.sv
// fault state report bank: state report, event memories, live supply status
`timescale 1ns/1ps

// Contract
// - channel 3 state sits in bits 7-5, 101 shutdown down to 000 playing.
// - channel 4 state sits in bits 4-2 with the same six codes.
// - bit 1 of the state report is 1 only when channel 3 load check passed.
// - bit 0 of the state report is 1 only when channel 4 load check passed.
// - both event memories clear on a software read; an event in that same cycle stays latched.
// - over-current events latch at bit 7 (channel 1) down to bit 4.
// - dc fault events latch at bit 3 (channel 1) down to bit 0.
// - supply memory holds gate fault at bit 5, por at 4, zeros at 7-6.
// - supply memory holds stage ov 3, battery ov 2, stage uv 1, battery uv 0.
// - live bit 7 shows any active warning, whatever its configuration.
// - live bit 6 shows any active fault, whatever its configuration.
// - live bit 5 shows a present gate fault, bit 4 reads zero.
// - live bits 3 and 2 show stage and battery overvoltage.
// - live bits 1 and 0 show stage and battery undervoltage.
module fsrb_top import fsrb_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] third_channel_state,
	input wire logic [2:0] fourth_channel_state,
	input wire logic ch3_load_check_ok,
	input wire logic ch4_load_check_ok,
	input wire logic [3:0] overcurrent,
	input wire logic [3:0] dc_fault,
	input wire logic gate_drive_supply_fault,
	input wire logic digital_supply_por,
	input wire logic power_stage_supply_overvoltage,
	input wire logic battery_overvoltage,
	input wire logic power_stage_supply_undervoltage,
	input wire logic battery_undervoltage,
	input wire logic any_warning,
	input wire logic any_fault,
	output logic irq
);

	// =========================================================
	// bus front end
	fsrb_acc_if acc ();

	fsrb_apb_port u_port (
		.clk(clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.acc(acc)
	);

	// =========================================================
	// address decode
	wire logic hit_state;
	wire logic hit_ocdc;
	wire logic hit_supply_mem;
	wire logic hit_live;
	wire logic hit_irq_status;
	wire logic hit_irq_mask;
	wire logic hit_any;

	assign hit_state = acc.mapped_ok & (acc.idx == IDX_CH34_STATE);
	assign hit_ocdc = acc.mapped_ok & (acc.idx == IDX_OCDC_MEM);
	assign hit_supply_mem = acc.mapped_ok & (acc.idx == IDX_SUPPLY_MEM);
	assign hit_live = acc.mapped_ok & (acc.idx == IDX_SUPPLY_LIVE);
	assign hit_irq_status = acc.mapped_ok & (acc.idx == IDX_IRQ_STATUS);
	assign hit_irq_mask = acc.mapped_ok & (acc.idx == IDX_IRQ_MASK);
	assign hit_any = hit_state | hit_ocdc | hit_supply_mem | hit_live |
		hit_irq_status | hit_irq_mask;

	wire logic rd_take;
	wire logic wr_take;

	assign rd_take = acc.take & ~acc.wr;
	assign wr_take = acc.take & acc.wr;

	// =========================================================
	// channel 3/4 state report
	logic [REG_W-1:0] channel34_state_report;
	wire logic [REG_W-1:0] next_channel34_state_report;

	assign next_channel34_state_report = {
		third_channel_state,
		fourth_channel_state,
		ch3_load_check_ok,
		ch4_load_check_ok
	};

	always_ff @(posedge clk) begin
		if (rst) begin
			channel34_state_report <= RST_CH34_STATE;
		end else begin
			channel34_state_report <= next_channel34_state_report;
		end
	end

	// =========================================================
	// over-current and dc fault memory
	wire logic [REG_W-1:0] ocdc_set;
	wire logic [REG_W-1:0] ocdc_clr;
	logic [REG_W-1:0] current_dc_event_latch;

	// input bit 3 is channel 1, so channel 1 lands on the top bit
	assign ocdc_set = {overcurrent, dc_fault};
	assign ocdc_clr = {REG_W{rd_take & hit_ocdc}};

	fsrb_event_latch #(
		.W(REG_W)
	) u_ocdc (
		.clk(clk),
		.rst(rst),
		.set(ocdc_set),
		.clr(ocdc_clr),
		.q(current_dc_event_latch)
	);

	// =========================================================
	// supply event memory
	wire logic [REG_W-1:0] supply_set_raw;
	wire logic [REG_W-1:0] supply_set;
	wire logic [REG_W-1:0] supply_clr;
	logic [REG_W-1:0] supply_event_latch;

	assign supply_set_raw = {
		2'h0,
		gate_drive_supply_fault,
		digital_supply_por,
		power_stage_supply_overvoltage,
		battery_overvoltage,
		power_stage_supply_undervoltage,
		battery_undervoltage
	};
	assign supply_set = supply_set_raw & SUPPLY_MEM_MASK;
	assign supply_clr = {REG_W{rd_take & hit_supply_mem}};

	fsrb_event_latch #(
		.W(REG_W)
	) u_supply (
		.clk(clk),
		.rst(rst),
		.set(supply_set),
		.clr(supply_clr),
		.q(supply_event_latch)
	);

	// =========================================================
	// live supply status
	logic [REG_W-1:0] supply_live_status;
	wire logic [REG_W-1:0] live_raw;
	wire logic [REG_W-1:0] next_supply_live_status;

	assign live_raw = {
		any_warning,
		any_fault,
		gate_drive_supply_fault,
		1'b0,
		power_stage_supply_overvoltage,
		battery_overvoltage,
		power_stage_supply_undervoltage,
		battery_undervoltage
	};
	assign next_supply_live_status = live_raw & SUPPLY_LIVE_MASK;

	always_ff @(posedge clk) begin
		if (rst) begin
			supply_live_status <= RST_LIVE;
		end else begin
			supply_live_status <= next_supply_live_status;
		end
	end

	// =========================================================
	// interrupt events
	// a channel entering shutdown or a load check passing is an edge
	// of the registered report, so a steady state fires only once
	wire logic ch3_down_now;
	wire logic ch4_down_now;
	wire logic ch3_down_was;
	wire logic ch4_down_was;
	wire logic [IRQ_W-1:0] irq_set;
	wire logic [IRQ_W-1:0] irq_clr;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;

	assign ch3_down_now =
		(third_channel_state == fsrb_protective_shutdown);
	assign ch4_down_now =
		(fourth_channel_state == fsrb_protective_shutdown);
	assign ch3_down_was =
		(channel34_state_report[CH3_STATE_LSB +: 3] ==
		fsrb_protective_shutdown);
	assign ch4_down_was =
		(channel34_state_report[CH4_STATE_LSB +: 3] ==
		fsrb_protective_shutdown);

	assign irq_set[IRQ_OC] = |overcurrent;
	assign irq_set[IRQ_DC] = |dc_fault;
	assign irq_set[IRQ_SUPPLY] = |supply_set;
	assign irq_set[IRQ_SHUTDOWN] = (ch3_down_now & ~ch3_down_was) |
		(ch4_down_now & ~ch4_down_was);
	assign irq_set[IRQ_LOAD_OK] =
		(ch3_load_check_ok & ~channel34_state_report[CH3_LOAD_OK_BIT]) |
		(ch4_load_check_ok & ~channel34_state_report[CH4_LOAD_OK_BIT]);

	// write one to clear; a new event in the same cycle wins
	assign irq_clr = (wr_take & hit_irq_status) ?
		pwdata[IRQ_W-1:0] : RST_IRQ;

	fsrb_event_latch #(
		.W(IRQ_W)
	) u_irq (
		.clk(clk),
		.rst(rst),
		.set(irq_set),
		.clr(irq_clr),
		.q(irq_status)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask <= RST_IRQ;
		end else if (wr_take & hit_irq_mask) begin
			irq_mask <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// =========================================================
	// read data
	// memories are read as they will stand after this edge, so an
	// event landing during the setup cycle is shown before the clear
	wire logic [REG_W-1:0] ocdc_view;
	wire logic [REG_W-1:0] supply_view;
	wire logic [REG_W-1:0] rd_byte;
	wire logic [IRQ_W-1:0] irq_view;
	wire logic [DATA_W-1:0] rd_word;

	assign ocdc_view = current_dc_event_latch | ocdc_set;
	assign supply_view = supply_event_latch | supply_set;
	assign irq_view = irq_status | irq_set;

	assign rd_byte =
		hit_state ? channel34_state_report :
		hit_ocdc ? ocdc_view :
		hit_supply_mem ? supply_view :
		hit_live ? supply_live_status :
		hit_irq_status ? {3'h0, irq_view} :
		hit_irq_mask ? {3'h0, irq_mask} :
		RST_MEM;
	assign rd_word = {24'h00_0000, rd_byte};

	// writes to the report registers are accepted and dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= RST_RDATA;
		end else if (acc.setup & ~acc.wr) begin
			prdata <= rd_word;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= acc.setup & ~hit_any;
		end
	end

endmodule

// >>> fsrb_checker.sv
// port assertions of the fault state report bank
`timescale 1ns/1ps
module fsrb_checker import fsrb_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] overcurrent,
	input wire logic [3:0] dc_fault,
	input wire logic any_warning,
	input wire logic any_fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ====
	// request shapes
	wire setup = psel && !penable;
	sequence rd(a);
		setup && !pwrite && paddr == a;
	endsequence
	sequence quiet_rd;
		rd(12'h03c) ##0 (overcurrent == 4'h0 && dc_fault == 4'h0);
	endsequence
	// ====
	// properties
	ready_after_setup_a: assert property (setup |=> pready)
		else $error("no answer after setup");
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	bad_address_a: assert property (setup && paddr[1:0] != 2'h0
		|=> pready && pslverr) else $error("misaligned access accepted");
	oc_latched_a: assert property (rd(12'h03c)
		|=> (prdata[7:4] & $past(overcurrent)) == $past(overcurrent))
		else $error("overcurrent event missing");
	dc_latched_a: assert property (rd(12'h03c)
		|=> (prdata[3:0] & $past(dc_fault)) == $past(dc_fault))
		else $error("dc fault event missing");
	sup_reserved_a: assert property (rd(12'h040) |=> prdata[31:6] == 0)
		else $error("reserved supply bits set");
	live_fault_a: assert property (rd(12'h044)
		##0 (any_fault && $past(any_fault)) |=> prdata[6])
		else $error("fault summary missing");
	live_warn_a: assert property (rd(12'h044)
		##0 (any_warning && $past(any_warning)) |=> prdata[7])
		else $error("warning summary missing");
	cleared_read_a: assert property (quiet_rd
		##1 (overcurrent == 4'h0 && dc_fault == 4'h0) ##1 quiet_rd
		|=> prdata[7:0] == 8'h00) else $error("memory not cleared");
endmodule

bind fsrb_top fsrb_checker i_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .overcurrent(overcurrent),
	.dc_fault(dc_fault), .any_warning(any_warning), .any_fault(any_fault));

// >>> fsrb_top_tb.sv
// self-checking bench of the fault state report bank
`timescale 1ns/1ps
module fsrb_top_tb import fsrb_pkg::*; ;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, got, r;
	logic pready, pslverr, irq, gerr, experr;
	logic [23:0] st = 24'h0;
	logic [31:0] seed = 32'h969cc8ec;
	int m_oc, m_sup, exp_rd, errors, comparisons;

	fsrb_top i_fsrb_top (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.third_channel_state(st[23:21]), .fourth_channel_state(st[20:18]),
		.ch3_load_check_ok(st[17]), .ch4_load_check_ok(st[16]),
		.overcurrent(st[15:12]), .dc_fault(st[11:8]),
		.gate_drive_supply_fault(st[7]), .digital_supply_por(st[6]),
		.power_stage_supply_overvoltage(st[5]), .battery_overvoltage(st[4]),
		.power_stage_supply_undervoltage(st[3]),
		.battery_undervoltage(st[2]), .any_warning(st[1]),
		.any_fault(st[0]));

	always #50 clk = ~clk;

	// ====
	// reference model, updated on every edge
	always @(posedge clk) begin
		if (rst) begin
			m_oc = 0;
			m_sup = 0;
		end else begin
			if (psel && penable && !pwrite && paddr == 12'h03c)
				m_oc = 0;
			if (psel && penable && !pwrite && paddr == 12'h040)
				m_sup = 0;
			// an event in the clearing cycle survives the clear
			m_oc = m_oc | st[15:8];
			m_sup = m_sup | st[7:2];
			if (psel && !penable) begin
				experr = paddr[1:0] != 2'h0 || !(paddr[11:2] inside
					{IDX_CH34_STATE, IDX_OCDC_MEM, IDX_SUPPLY_MEM,
					IDX_SUPPLY_LIVE, IDX_IRQ_STATUS, IDX_IRQ_MASK});
				case (paddr)
					12'h038: exp_rd = st[23:16];
					12'h03c: exp_rd = m_oc;
					12'h040: exp_rd = m_sup;
					default: exp_rd = {st[1:0], st[7], 1'h0, st[5:2]};
				endcase
			end
		end
	end

	// ====
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp1(input logic g, input logic e);
		cmp32({31'h0, g}, {31'h0, e});
	endtask

	task tally_and_finish();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// request is held until pready is seen; released by idle only
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			errors++;
			tally_and_finish();
		end
		got = prdata;
		gerr = pslverr;
		cmp1(gerr, experr);
	endtask

	task automatic rd(input logic [11:0] a);
		bus(1'h0, a, 32'h0);
		if (a >= 12'h038 && a <= 12'h044 && a[1:0] == 2'h0)
			cmp32(got, exp_rd);
	endtask

	task automatic idle(input int k);
		psel <= 1'h0;
		penable <= 1'h0;
		repeat (k) @(posedge clk);
	endtask

	// ====
	// scenarios
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rd(12'h03c);
		rd(12'h044);
		idle(1);
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			st <= {3'(r[31:29] % 3'h6), 3'(r[28:26] % 3'h6), r[17:0]};
			idle(3);
			rd(12'h038);
			rd(12'h03c);
			rd(12'h040);
			rd(12'h044);
			bus(1'h1, 12'h03c, rnd());
			rd(12'h03c);
			st <= st & 24'hff0003;
			idle(1);
			rd(12'h03c);
			rd(12'h03c);
			rd(12'h040);
			rd(12'h040);
			idle(1);
		end
		rd(12'h03d);
		rd(12'h0fc);
		bus(1'h1, 12'h044, 32'hffffffff);
		bus(1'h1, 12'h030, 32'hff);
		rd(12'h040);
		st <= 24'h0;
		idle(2);
		bus(1'h1, 12'h080, 32'h1f);
		bus(1'h1, 12'h084, 32'h0);
		st <= 24'h008000;
		idle(3);
		cmp1(irq, 1'h0);
		bus(1'h1, 12'h084, 32'h1);
		idle(3);
		cmp1(irq, 1'h1);
		rd(12'h080);
		cmp1(got[0], 1'h1);
		st <= 24'h0;
		bus(1'h1, 12'h080, 32'h1);
		idle(3);
		cmp1(irq, 1'h0);
		tally_and_finish();
	end
endmodule
